// ---- src/hpc_pkg.sv ----
// package of constants and carrier types for the host port control block
package hpc_pkg;
    // data bus and register space widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int NREGS  = 16;
    // interrupt source groups: global, framer, liu, bert
    localparam int NSRC   = 4;
    // reset values
    localparam logic [7:0] REG_RST  = 8'h00;
    localparam logic [3:0] MASK_RST = 4'hf;
    // register indices inside the small control space
    localparam logic [3:0] IDX_STATUS   = 4'h0;
    localparam logic [3:0] IDX_MASK     = 4'h1;
    localparam logic [3:0] IDX_CLKCFG   = 4'h2;
    // clock config field positions
    localparam int CLK_PS_LSB  = 0;
    localparam int CLK_FAM_BIT = 2;
    localparam int CLK_DIR_BIT = 3;
    localparam int CLK_SRC_LSB = 4;
    // reference clock divider half period in clk cycles (25 MHz base)
    localparam int REF_HALF_E1 = 6;
    localparam int REF_HALF_T1 = 8;
    // identification value, arbitrary
    localparam logic [7:0] ID_CODE = 8'h5a;

    // parallel port pins as seen by the device
    typedef struct packed {
        logic              chip_select_n;
        logic              read_strobe_n;
        logic              write_strobe_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data_in;
    } hpc_bus_t;

    // backplane reference source choice
    typedef enum logic [1:0] {
        SRC_MCLK = 2'b00,
        SRC_REF  = 2'b01,
        SRC_LINE = 2'b11
    } hpc_src_t;
endpackage

// ---- src/hpc_ref_div.sv ----
// reference clock divider producing a one-cycle enable and a level
`timescale 1ns/1ps
module hpc_ref_div
    import hpc_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // control
    input  wire logic family_e1,
    // outputs
    output logic      ref_level,
    output logic      ref_tick
);
    logic [3:0] cnt_r;   // half period counter
    logic [3:0] half;    // selected half period

    // half period per clock family
    assign half = family_e1 ? 4'(REF_HALF_E1) : 4'(REF_HALF_T1);

    // counter wrap gives one-cycle tick
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_r    <= 4'h0;
            ref_tick <= 1'b0;
        end else if (cnt_r >= half - 4'h1) begin
            cnt_r    <= 4'h0;
            ref_tick <= 1'b1;
        end else begin
            cnt_r    <= cnt_r + 4'h1;
            ref_tick <= 1'b0;
        end
    end

    // toggles on each tick
    always_ff @(posedge clk) begin
        if (srst) begin
            ref_level <= 1'b0;
        end else if (ref_tick) begin
            ref_level <= ~ref_level;
        end
    end
endmodule

// ---- src/hpc_top.sv ----
// host port mode, interrupt, reset and test control of the transceiver
// Notes on behaviour
// - write data latched on write strobe rise
// - interrupt low on any unmasked event
// - interrupt released once all pending events are serviced or masked, or when io floats
// - masks at global, framer, liu, bert
// - serial select picks parallel or spi
// - bus style picks strobe meaning
// - master clock family and prescale selectable
// - global reset clears all registers except mask_r and wr_prev_r, which it sets to all ones
// - reference pin input may time backplane
// - reference pin output drives reference clock
// - enable and test reset low float io
// - enable high gives normal io
// - test reset clears test controller asynchronously
// - test reset low returns normal operation
// - read drives data while strobes low
`timescale 1ns/1ps
module hpc_top
    import hpc_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              global_reset_n,
    // parallel host port
    input  wire hpc_bus_t          bus,
    input  wire logic              serial_select,
    input  wire logic              bus_style_select,
    output logic [DATA_W-1:0]      data_out,
    output logic                   data_oe,
    // interrupt pin
    input  wire logic [NSRC-1:0]   irq_events,
    output logic                   interrupt_out_n_o,
    output logic                   interrupt_out_n_oe,
    // master clock selection pins
    input  wire logic              master_clock_prescale_0,
    input  wire logic              master_clock_prescale_1,
    input  wire logic              master_clock_family_select,
    // reference clock pin
    input  wire logic              reference_clock_pin_i,
    input  wire logic              line_clock_in,
    output logic                   reference_clock_pin_o,
    output logic                   reference_clock_pin_oe,
    output logic                   backplane_ref,
    output logic                   adapted_family_e1,
    output logic [1:0]             clock_prescale,
    // test pins
    input  wire logic              digital_io_enable,
    input  wire logic              test_port_reset_n,
    output logic                   io_float,
    output logic                   id_mode,
    output logic                   test_ctrl_reset
);
    // ==========================================================
    // reset and mode decode
    logic rst_all;                    // combined reset
    logic spi_mode;                   // serial host port selected
    logic ds_style;                   // ds/rw strobe style
    logic wr_active_n;                // write strobe, style mapped
    logic rd_active_n;                // read strobe, style mapped
    logic wr_prev_r;                  // last write strobe level
    logic [DATA_W-1:0] regs_r [NREGS];// register storage
    logic [NSRC-1:0] pend_r;          // sticky pending events
    logic [NSRC-1:0] mask_r;          // per level mask, 1 masks
    logic id_r;                       // identification mode
    logic tr_prev_r;                  // last test reset level
    logic ref_level;                  // divider clock level
    logic ref_tick;                   // divider tick, unused beyond level

    assign rst_all        = srst | ~global_reset_n;
    assign spi_mode       = serial_select;
    // spi mode forces separate-strobe style regardless of pin
    assign ds_style       = bus_style_select & ~spi_mode;

    // strobe meaning per style
    always_comb begin
        if (ds_style) begin
            // data strobe plus direction on the write pin
            wr_active_n = bus.read_strobe_n | bus.write_strobe_n;
            rd_active_n = bus.read_strobe_n | ~bus.write_strobe_n;
        end else begin
            wr_active_n = bus.write_strobe_n;
            rd_active_n = bus.read_strobe_n;
        end
    end

    // ==========================================================
    // write capture on strobe rising edge
    always_ff @(posedge clk) begin
        if (rst_all) begin
            wr_prev_r <= 1'b1;
        end else begin
            wr_prev_r <= wr_active_n;
        end
    end

    // register file update
    always_ff @(posedge clk) begin
        if (rst_all) begin
            for (int i = 0; i < NREGS; i++) begin
                regs_r[i] <= REG_RST;
            end
        end else if (!spi_mode && !wr_prev_r && wr_active_n
                     && !bus.chip_select_n) begin
            regs_r[bus.addr] <= bus.data_in;
        end
    end

    // ==========================================================
    // interrupt masks and pending
    always_ff @(posedge clk) begin
        if (rst_all) begin
            mask_r <= MASK_RST;
        end else begin
            mask_r <= regs_r[IDX_MASK][NSRC-1:0];
        end
    end

    // set wins over clear; write one to status clears
    always_ff @(posedge clk) begin
        if (rst_all) begin
            pend_r <= '0;
        end else begin
            if (!spi_mode && !wr_prev_r && wr_active_n && !bus.chip_select_n
                && bus.addr == IDX_STATUS) begin
                pend_r <= (pend_r & ~bus.data_in[NSRC-1:0]) | irq_events;
            end else begin
                pend_r <= pend_r | irq_events;
            end
        end
    end

    // open drain style interrupt pin
    always_ff @(posedge clk) begin
        if (rst_all) begin
            interrupt_out_n_oe <= 1'b0;
        end else begin
            interrupt_out_n_oe <= |(pend_r & ~mask_r) & ~io_float;
        end
    end
    assign interrupt_out_n_o = 1'b0;

    // ==========================================================
    // read path
    always_ff @(posedge clk) begin
        if (rst_all) begin
            data_out <= '0;
        end else if (id_r) begin
            data_out <= ID_CODE;
        end else if (bus.addr == IDX_STATUS) begin
            data_out <= {{(DATA_W-NSRC){1'b0}}, pend_r};
        end else begin
            data_out <= regs_r[bus.addr];
        end
    end
    assign data_oe = !spi_mode && !rd_active_n && !bus.chip_select_n
                     && !io_float;

    // ==========================================================
    // clock selection
    always_ff @(posedge clk) begin
        if (rst_all) begin
            clock_prescale    <= 2'b00;
            adapted_family_e1 <= 1'b0;
        end else begin
            clock_prescale    <= {master_clock_prescale_1, master_clock_prescale_0};
            adapted_family_e1 <= master_clock_family_select;
        end
    end

    hpc_ref_div u_div (
        .clk       (clk),
        .srst      (rst_all),
        .family_e1 (adapted_family_e1),
        .ref_level (ref_level),
        .ref_tick  (ref_tick)
    );

    // reference pin direction and backplane source
    always_ff @(posedge clk) begin
        if (rst_all) begin
            reference_clock_pin_o <= 1'b0;
            backplane_ref         <= 1'b0;
        end else begin
            reference_clock_pin_o <= ref_level;
            case (hpc_src_t'(regs_r[IDX_CLKCFG][CLK_SRC_LSB +: 2]))
                SRC_REF:  backplane_ref <= reference_clock_pin_i;
                SRC_LINE: backplane_ref <= line_clock_in;
                SRC_MCLK: backplane_ref <= ref_level;
                default:  backplane_ref <= ref_level;
            endcase
        end
    end
    assign reference_clock_pin_oe = regs_r[IDX_CLKCFG][CLK_DIR_BIT] & ~io_float;

    // ==========================================================
    // test controls
    assign io_float        = ~digital_io_enable & ~test_port_reset_n;
    assign test_ctrl_reset = ~test_port_reset_n;

    // rising test reset enters id mode, low leaves it
    always_ff @(posedge clk) begin
        if (rst_all) begin
            tr_prev_r <= 1'b0;
            id_r      <= 1'b0;
        end else begin
            tr_prev_r <= test_port_reset_n;
            if (!test_port_reset_n) begin
                id_r <= 1'b0;
            end else if (!tr_prev_r) begin
                id_r <= 1'b1;
            end
        end
    end
    assign id_mode = id_r;
endmodule

// ---- verif/hpc_props.sv ----
// checker of the host port control relations
`timescale 1ns/1ps
module hpc_props
    import hpc_pkg::*;
(
    // clock and resets
    input wire logic     clk,
    input wire logic     srst,
    input wire logic     global_reset_n,
    // host port
    input wire hpc_bus_t bus,
    input wire logic     serial_select,
    input wire logic     bus_style_select,
    input wire logic     data_oe,
    input wire logic     interrupt_out_n_oe,
    // test pins
    input wire logic     digital_io_enable,
    input wire logic     test_port_reset_n,
    input wire logic     io_float,
    input wire logic     id_mode,
    input wire logic     test_ctrl_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst || !global_reset_n);
    // ==========
    // host port idle for four samples
    sequence s_quiet;
        bus.chip_select_n [*4];
    endsequence
    property p_float;
        io_float == (!digital_io_enable && !test_port_reset_n);
    endproperty
    property p_norm;
        digital_io_enable |-> !io_float;
    endproperty
    property p_tst;
        test_ctrl_reset == !test_port_reset_n;
    endproperty
    property p_oe;
        !bus_style_select && !serial_select && !io_float
            |-> data_oe == (!bus.chip_select_n && !bus.read_strobe_n);
    endproperty
    property p_ser;
        serial_select |-> !data_oe;
    endproperty
    property p_hold;
        s_quiet ##0 interrupt_out_n_oe |=> interrupt_out_n_oe;
    endproperty
    property p_rst;
        disable iff (srst) !global_reset_n |=> !interrupt_out_n_oe && !id_mode;
    endproperty
    property p_idm;
        !test_port_reset_n |=> !id_mode;
    endproperty
    a_float: assert property (p_float) else $error("io float wrong");
    a_norm: assert property (p_norm) else $error("io floated while enabled");
    a_tst: assert property (p_tst) else $error("test reset wrong");
    a_oe: assert property (p_oe) else $error("read drive wrong");
    a_ser: assert property (p_ser) else $error("drive in serial mode");
    a_hold: assert property (p_hold) else $error("interrupt dropped unserviced");
    a_rst: assert property (p_rst) else $error("reset did not clear");
    a_idm: assert property (p_idm) else $error("id mode kept");
endmodule
bind hpc_top hpc_props u_props (.*);

// ---- verif/hpc_host.sv ----
// host processor model driving the parallel port
`timescale 1ns/1ps
module hpc_host
    import hpc_pkg::*;
(
    // clock
    input  wire logic              clk,
    // parallel port toward the device
    output hpc_bus_t               bus,
    input  wire logic [DATA_W-1:0] data_out
);
    // idle: deselected, strobes high
    initial bus = '{1'b1, 1'b1, 1'b1, 4'h0, 8'h00};
    // write: strobe low one cycle, rise while selected
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus.chip_select_n = 1'b0;
        bus.write_strobe_n = 1'b0;
        bus.addr = a;
        bus.data_in = d;
        @(posedge clk);
        #1 bus.write_strobe_n = 1'b1;
        @(posedge clk);
        #1 bus.chip_select_n = 1'b1;
        bus.addr = ~a;
        bus.data_in = ~d;
        @(posedge clk);
        #1;
    endtask
    // data strobe style write: direction low, data strobe low one cycle
    task automatic ds_wr(input logic [3:0] a, input logic [7:0] d);
        bus.chip_select_n = 1'b0;
        bus.read_strobe_n = 1'b0;
        bus.write_strobe_n = 1'b0;
        bus.addr = a;
        bus.data_in = d;
        @(posedge clk);
        #1 bus.read_strobe_n = 1'b1;
        @(posedge clk);
        #1 bus.chip_select_n = 1'b1;
        bus.write_strobe_n = 1'b1;
        bus.addr = ~a;
        bus.data_in = ~d;
        @(posedge clk);
        #1;
    endtask
    // read: data taken two edges after select
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        bus.chip_select_n = 1'b0;
        bus.read_strobe_n = 1'b0;
        bus.addr = a;
        repeat (2) @(posedge clk);
        d = data_out;
        #1 bus.chip_select_n = 1'b1;
        bus.read_strobe_n = 1'b1;
        bus.addr = ~a;
        @(posedge clk);
        #1;
    endtask
endmodule

// ---- verif/tb.sv ----
// self-checking bench of the host port control block
`timescale 1ns/1ps
module tb;
    import hpc_pkg::*;
    // ==========
    // design pins
    logic              clk, srst, global_reset_n, serial_select, bus_style_select;
    logic              master_clock_prescale_0, master_clock_prescale_1, io_float;
    logic              master_clock_family_select, reference_clock_pin_i, line_clock_in;
    logic              digital_io_enable, test_port_reset_n, id_mode, test_ctrl_reset;
    logic [NSRC-1:0]   irq_events;
    hpc_bus_t          bus;
    logic [DATA_W-1:0] data_out;
    logic              data_oe, interrupt_out_n_o, interrupt_out_n_oe, reference_clock_pin_o;
    logic              reference_clock_pin_oe, backplane_ref, adapted_family_e1;
    logic [1:0]        clock_prescale;
    int                bad_count, tests_run, seed, n, i;
    logic [7:0]        d, q;
    hpc_top  dut  (.*);
    hpc_host host (.clk, .bus, .data_out);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // free clock pins wander at random
    always @(posedge clk) begin
        #1;
        {master_clock_prescale_0, master_clock_prescale_1, master_clock_family_select,
         reference_clock_pin_i, line_clock_in} <= 5'($random(seed));
    end
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic pulse(input int s);
        irq_events[s] = 1'b1;
        tick(1);
        irq_events = '0;
        tick(3);
    endtask
    function automatic logic [7:0] exp_mask(input logic [7:0] v);
        // mask register keeps the whole written byte
        return v;
    endfunction
    task automatic close_out;
        $display("counts: %0d compared, %0d mismatched", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        seed = 32'h119c;
        bad_count = 0;
        tests_run = 0;
        srst = 1'b1;
        global_reset_n = 1'b1;
        serial_select = 1'b0;
        bus_style_select = 1'b0;
        irq_events = '0;
        digital_io_enable = 1'b1;
        test_port_reset_n = 1'b0;
        tick(6);
        srst = 1'b0;
        tick(1);
        // raise, clear and mask each source
        for (i = 0; i < NSRC; i++) begin
            pulse(i);
            chk(interrupt_out_n_oe, 8'h01);
            host.wr(IDX_STATUS, 8'(1 << i));
            tick(3);
            chk(interrupt_out_n_oe, 8'h00);
            host.wr(IDX_MASK, 8'(1 << i));
            pulse(i);
            chk(interrupt_out_n_oe, 8'h00);
            host.wr(IDX_STATUS, 8'h0f);
            host.wr(IDX_MASK, 8'h00);
        end
        $display("irq test done");
        for (n = 0; n < 8; n++) begin
            d = (n == 0) ? 8'hff : 8'($random(seed));
            host.wr(IDX_MASK, d);
            host.rd(IDX_MASK, q);
            chk(q, exp_mask(d));
        end
        // writes refused in serial mode
        serial_select = 1'b1;
        host.wr(IDX_MASK, ~d);
        serial_select = 1'b0;
        host.rd(IDX_MASK, q);
        chk(q, exp_mask(d));
        // data strobe style write, read back in the same style
        bus_style_select = 1'b1;
        host.ds_wr(IDX_MASK, 8'h3c);
        host.rd(IDX_MASK, q);
        chk(q, exp_mask(8'h3c));
        bus_style_select = 1'b0;
        global_reset_n = 1'b0;
        tick(2);
        global_reset_n = 1'b1;
        tick(1);
        host.rd(IDX_MASK, q);
        chk(q, 8'h00);
        $display("register test done");
        host.wr(IDX_CLKCFG, 8'h08);
        tick(2);
        chk(reference_clock_pin_oe, 8'h01);
        n = 0;
        repeat (40) begin
            q[0] = reference_clock_pin_o;
            tick(1);
            if (reference_clock_pin_o !== q[0]) n++;
        end
        chk(8'(n != 0), 8'h01);
        digital_io_enable = 1'b0;
        tick(1);
        chk(io_float, 8'h01);
        chk(data_oe, 8'h00);
        digital_io_enable = 1'b1;
        tick(1);
        chk(io_float, 8'h00);
        test_port_reset_n = 1'b1;
        tick(2);
        chk(id_mode, 8'h01);
        host.rd(4'h7, q);
        chk(q, ID_CODE);
        test_port_reset_n = 1'b0;
        tick(2);
        chk(id_mode, 8'h00);
        chk(test_ctrl_reset, 8'h01);
        $display("test pin test done");
        close_out();
    end
endmodule
